// File: common/rswps_pkg.sv
/*
 reset/watchdog/power-save controller package: control register layout,
 reset vectors, timing constants, states and carrier structs.
 assumes a 10 MHz system clock.
*/
package rswps_pkg;
    // reset_control_register bit positions
    localparam int RCR_POR_BIT    = 0;
    localparam int RCR_BOR_BIT    = 1;
    localparam int RCR_IDLE_BIT   = 2;
    localparam int RCR_SLEEP_BIT  = 3;
    localparam int RCR_WATCHDOG_TIMEOUT_FLAG_BIT   = 4;
    localparam int RCR_WATCHDOG_SOFT_ENABLE_BIT = 5;
    localparam int RCR_SWR_BIT    = 6;
    localparam int RCR_EXTERNAL_PIN_RESET_FLAG_BIT   = 7;
    localparam int RCR_LOW_VOLTAGE_THRESHOLD_FIELD_LSB   = 8;
    localparam int RCR_LOW_VOLTAGE_DETECT_ENABLE_BIT  = 12;
    localparam int RCR_REFERENCE_STABLE_FLAG_BIT   = 13;
    localparam int RCR_ILLEGAL_OPERATION_RESET_FLAG_BIT = 14;
    localparam int RCR_TRAP_RESET_FLAG_BIT  = 15;
    localparam logic [15:0] RCR_RESET_VAL = 16'h0003;
    localparam logic [15:0] RCR_WR_MASK   = 16'hDFFF;

    localparam logic [23:0] RESET_VECTOR   = 24'h000000;
    localparam logic [23:0] CLK_FAIL_VECTOR = 24'h000004;
    localparam logic [23:0] PC_STEP        = 24'h000002;

    localparam int CLK_MHZ          = 10;
    localparam int SHORT_DELAY_US   = 10;
    localparam int SHORT_DELAY_CYC  = SHORT_DELAY_US * CLK_MHZ;
    localparam int WDT_WIDTH        = 16;
    localparam int OST_CYC          = 1024;
    localparam int REF_SETTLE_CYC   = 200;

    localparam logic [1:0] PSV_SLEEP = 2'h0;
    localparam logic [1:0] PSV_IDLE  = 2'h1;

    typedef enum logic [2:0] {
        RSW_RUN, RSW_SLEEP, RSW_IDLE, RSW_WAKE_DLY, RSW_WAIT_CLK
    } rsw_state_t;

    typedef struct packed {
        logic        por;
        logic        bor;
        logic        ext_pin;
        logic        sw;
        logic        trap;
        logic        illegal_op;
    } rsw_reset_req_t;

    typedef struct packed {
        logic        osc_crystal;
        logic        pll_used;
        logic        lp_kept;
        logic        fail_safe_clock_monitor_en;
        logic        clk_switch_en;
        logic [1:0]  cur_osc;
        logic [1:0]  cfg_osc;
    } rsw_clk_cfg_t;
endpackage

// File: verilog/rswps_ctrl.sv
/*
 reset cause, watchdog and sleep/idle controller.
 assumes synchronous event pulses from the core, an RC tick from the
 low-power oscillator and oscillator/pll status pins.
*/
`timescale 1ns/10ps
`default_nettype none

// Contract
// - por loads pc zero, sets por and bor; bor sets bor only, clears por.
// - pin reset when running: vector zero, set ext, clear sw, wdt, idle, sleep.
// - software reset: vector zero, set sw, clear ext, wdt, idle, sleep.
// - pin reset in sleep: set ext and sleep, clear wdt and idle.
// - pin reset in idle: set ext and idle, clear wdt and sleep.
// - watchdog overflow outside sleep and idle resets to zero, sets wdt flag only.
// - watchdog overflow in sleep wakes, resumes at pc plus 2, sets sleep, wdt.
// - interrupt wake from sleep sets sleep flag and loads interrupt vector.
// - watchdog counts on rc ticks independent of main clock.
// - fuse bit high enables watchdog permanently; erased value is one.
// - fuse low lets soft enable at bit 5 run the watchdog.
// - threshold field bits 11:8, detector enable bit 12.
// - read-only bit 13 shows reference stable.
// - power-save instruction enters sleep or idle by operand.
// - sleep stops cpu, peripheral, and oscillator unless lp_kept; keeps rc, bor, lvd if enabled.
// - sleep ends on enabled interrupt, any reset or watchdog overflow.
// - wake restarts prior clock; after por or bor use fuse source.
// - wake waits short delay, then startup timer (crystal, not lp_kept) and pll lock when used.
// - clock still dead: fail-safe traps to fast rc, else stall.
// - of the resets only a pin reset in sleep sets sleep flag; por clears it.
// - idle stops cpu clock only; wake resumes at once, at next instruction or at interrupt vector.
// - idle flag set on pin reset in idle and idle wakes; wdt wake sets wdt.
// - all status and control bits are software readable; all but bit 13 are writable.
module rswps_ctrl
    import rswps_pkg::*;
#(
    parameter int WDT_W = WDT_WIDTH,
    parameter int OST_N = OST_CYC
) (
    input  wire logic           i_clk,          // 10 MHz system clock
    input  wire logic           i_sys_rst,      // async reset, high
    input  wire rsw_reset_req_t i_rst_req,      // reset cause pulses
    input  wire logic           i_rc_tick,      // low-power rc clock pin
    input  wire logic           i_wdt_fuse_en,  // watchdog_fuse_enable
    input  wire logic           i_wdt_clr,      // clear instruction pulse
    input  wire logic           i_psv_exec,     // power-save instruction pulse
    input  wire logic [1:0]     i_psv_mode,     // its operand
    input  wire logic           i_irq_wake,     // enabled interrupt at priority
    input  wire logic [23:0]    i_irq_vector,   // that interrupt's vector
    input  wire logic [23:0]    i_pc,           // current program counter
    input  wire rsw_clk_cfg_t   i_clk_cfg,      // clock source settings
    input  wire logic           i_pll_lock,     // pll locked pin
    input  wire logic           i_osc_running,  // crystal running pin
    input  wire logic           i_rcr_we,       // control register write
    input  wire logic [15:0]    i_rcr_wdata,    // write data
    output logic [15:0]         o_rcr,          // reset_control_register
    output logic                o_sys_reset,    // core held in reset
    output logic                o_pc_load,      // load pc pulse
    output logic [23:0]         o_pc_value,     // value to load
    output logic                o_cpu_clk_en,   // cpu clock gate
    output logic                o_periph_clk_en,// peripheral clock gate
    output logic                o_osc_en,       // on-chip oscillator enable
    output logic                o_rc_en,        // low-power rc enable
    output logic                o_lvd_en,       // detector active
    output logic [3:0]          o_lvd_level,    // detector threshold
    output logic                o_clk_fail_trap,// fail-safe trap pulse
    output logic                o_use_fast_rc,  // switched to fast rc
    output logic [1:0]          o_osc_sel       // oscillator chosen on wake
);
    initial begin
        if (WDT_W < 4 || WDT_W > 32) $error("rswps_ctrl: bad WDT_W");
        if (OST_N < 1 || OST_N > 65535) $error("rswps_ctrl: bad OST_N");
    end

    typedef struct packed {
        rsw_state_t  st;
        logic [15:0] rcr;
        logic [WDT_W-1:0] wdt;
        logic [15:0] dly;
        logic [7:0]  ref_cnt;
        logic [2:0]  rc_sync;
        logic        rc_lvl;
        logic        ost_pend;
        logic        sys_reset;
        logic        pc_load;
        logic [23:0] pc_value;
        logic        cpu_en;
        logic        per_en;
        logic        osc_en;
        logic        rc_en;
        logic        trap;
        logic        fast_rc;
        logic [1:0]  osc_sel;
    } rsw_regs_t;

    rsw_regs_t s_r;
    rsw_regs_t s_nxt;

    function automatic logic [15:0] set_flags(input logic [15:0] v,
                                              input logic [15:0] setm,
                                              input logic [15:0] clrm);
        set_flags = (v & ~clrm) | setm;
    endfunction

    function automatic logic [15:0] bit16(input int b);
        bit16 = 16'h0001 << b;
    endfunction

    logic       wdt_run;
    logic       rc_edge;
    logic       wdt_ovf;
    logic [15:0] clr4;

    always_comb begin
        s_nxt = s_r;
        s_nxt.pc_load = 1'b0;
        s_nxt.trap = 1'b0;
        s_nxt.sys_reset = 1'b0;
        // rc tick crosses in: change counts once stages 2 and 3 agree
        s_nxt.rc_sync = {s_r.rc_sync[1:0], i_rc_tick};
        if (s_r.rc_sync[2] == s_r.rc_sync[1]) begin
            s_nxt.rc_lvl = s_r.rc_sync[2];
        end
        rc_edge = s_nxt.rc_lvl & ~s_r.rc_lvl;
        wdt_run = i_wdt_fuse_en | s_r.rcr[RCR_WATCHDOG_SOFT_ENABLE_BIT];
        wdt_ovf = wdt_run && rc_edge && (&s_r.wdt);
        clr4 = bit16(RCR_EXTERNAL_PIN_RESET_FLAG_BIT) | bit16(RCR_SWR_BIT) | bit16(RCR_WATCHDOG_TIMEOUT_FLAG_BIT)
             | bit16(RCR_IDLE_BIT) | bit16(RCR_SLEEP_BIT);
        s_nxt.rc_en = wdt_run;
        if (i_wdt_clr || !wdt_run) begin
            s_nxt.wdt = '0;
        end else if (rc_edge) begin
            s_nxt.wdt = s_r.wdt + 1'b1;
        end
        if (i_rcr_we) begin
            s_nxt.rcr = (i_rcr_wdata & RCR_WR_MASK)
                      | (s_r.rcr & ~RCR_WR_MASK);
        end
        if (s_r.ref_cnt != 8'(REF_SETTLE_CYC)) begin
            s_nxt.ref_cnt = s_r.ref_cnt + 8'h01;
        end
        s_nxt.rcr[RCR_REFERENCE_STABLE_FLAG_BIT] = (s_r.ref_cnt == 8'(REF_SETTLE_CYC));

        if (i_rst_req.por) begin
            s_nxt.rcr = set_flags(s_nxt.rcr,
                bit16(RCR_POR_BIT) | bit16(RCR_BOR_BIT),
                clr4 | bit16(RCR_TRAP_RESET_FLAG_BIT) | bit16(RCR_ILLEGAL_OPERATION_RESET_FLAG_BIT));
            s_nxt.osc_sel = i_clk_cfg.cfg_osc;
        end else if (i_rst_req.bor) begin
            s_nxt.rcr = set_flags(s_nxt.rcr, bit16(RCR_BOR_BIT),
                                  bit16(RCR_POR_BIT));
            s_nxt.osc_sel = i_clk_cfg.cfg_osc;
        end else if (i_rst_req.ext_pin) begin
            if (s_r.st == RSW_SLEEP) begin
                s_nxt.rcr = set_flags(s_nxt.rcr,
                    bit16(RCR_EXTERNAL_PIN_RESET_FLAG_BIT) | bit16(RCR_SLEEP_BIT),
                    bit16(RCR_WATCHDOG_TIMEOUT_FLAG_BIT) | bit16(RCR_IDLE_BIT));
            end else if (s_r.st == RSW_IDLE) begin
                s_nxt.rcr = set_flags(s_nxt.rcr,
                    bit16(RCR_EXTERNAL_PIN_RESET_FLAG_BIT) | bit16(RCR_IDLE_BIT),
                    bit16(RCR_WATCHDOG_TIMEOUT_FLAG_BIT) | bit16(RCR_SLEEP_BIT));
            end else begin
                s_nxt.rcr = set_flags(s_nxt.rcr, bit16(RCR_EXTERNAL_PIN_RESET_FLAG_BIT), clr4);
            end
        end else if (i_rst_req.sw) begin
            s_nxt.rcr = set_flags(s_nxt.rcr, bit16(RCR_SWR_BIT), clr4);
        end else if (i_rst_req.trap) begin
            s_nxt.rcr = set_flags(s_nxt.rcr, bit16(RCR_TRAP_RESET_FLAG_BIT), 16'h0000);
        end else if (i_rst_req.illegal_op) begin
            s_nxt.rcr = set_flags(s_nxt.rcr, bit16(RCR_ILLEGAL_OPERATION_RESET_FLAG_BIT), 16'h0000);
        end else if (wdt_ovf && s_r.st == RSW_SLEEP) begin
            s_nxt.rcr = set_flags(s_nxt.rcr,
                bit16(RCR_WATCHDOG_TIMEOUT_FLAG_BIT) | bit16(RCR_SLEEP_BIT), 16'h0000);
        end else if (wdt_ovf && s_r.st == RSW_IDLE) begin
            s_nxt.rcr = set_flags(s_nxt.rcr,
                bit16(RCR_WATCHDOG_TIMEOUT_FLAG_BIT) | bit16(RCR_IDLE_BIT), 16'h0000);
        end else if (wdt_ovf) begin
            s_nxt.rcr = set_flags(s_nxt.rcr, bit16(RCR_WATCHDOG_TIMEOUT_FLAG_BIT), clr4);
        end else if (i_irq_wake && s_r.st == RSW_SLEEP) begin
            s_nxt.rcr = set_flags(s_nxt.rcr, bit16(RCR_SLEEP_BIT), 16'h0000);
        end else if (i_irq_wake && s_r.st == RSW_IDLE) begin
            s_nxt.rcr = set_flags(s_nxt.rcr, bit16(RCR_IDLE_BIT), 16'h0000);
        end

        if (|i_rst_req || (wdt_ovf && s_r.st != RSW_SLEEP && s_r.st != RSW_IDLE)) begin
            s_nxt.sys_reset = 1'b1;
            s_nxt.pc_load = 1'b1;
            s_nxt.pc_value = RESET_VECTOR;
            s_nxt.wdt = '0;
            s_nxt.cpu_en = 1'b1;
            s_nxt.per_en = 1'b1;
            s_nxt.osc_en = 1'b1;
            s_nxt.st = RSW_RUN;
            if (s_r.st == RSW_SLEEP) begin
                s_nxt.cpu_en = 1'b0;
                s_nxt.per_en = 1'b0;
                s_nxt.ost_pend = i_clk_cfg.osc_crystal & ~i_clk_cfg.lp_kept;
                s_nxt.dly = 16'(SHORT_DELAY_CYC);
                s_nxt.st = RSW_WAKE_DLY;
            end
        end else begin
            case (s_r.st)
                RSW_RUN: begin
                    if (i_psv_exec) begin
                        s_nxt.cpu_en = 1'b0;
                        if (i_psv_mode == PSV_SLEEP) begin
                            s_nxt.per_en = 1'b0;
                            s_nxt.osc_en = i_clk_cfg.lp_kept;
                            s_nxt.st = RSW_SLEEP;
                        end else begin
                            s_nxt.st = RSW_IDLE;
                        end
                    end
                end
                RSW_SLEEP: begin
                    if (wdt_ovf || i_irq_wake) begin
                        s_nxt.pc_value = wdt_ovf ? (i_pc + PC_STEP) : i_irq_vector;
                        s_nxt.osc_en = 1'b1;
                        if (i_clk_cfg.clk_switch_en) begin
                            s_nxt.osc_sel = i_clk_cfg.cur_osc;
                        end
                        s_nxt.ost_pend = i_clk_cfg.osc_crystal & ~i_clk_cfg.lp_kept;
                        s_nxt.dly = 16'(SHORT_DELAY_CYC);
                        s_nxt.st = RSW_WAKE_DLY;
                    end
                end
                RSW_IDLE: begin
                    if (wdt_ovf || i_irq_wake) begin
                        s_nxt.pc_load = i_irq_wake;
                        s_nxt.pc_value = i_irq_vector;
                        s_nxt.cpu_en = 1'b1;
                        s_nxt.st = RSW_RUN;
                    end
                end
                RSW_WAKE_DLY: begin
                    s_nxt.osc_en = 1'b1;
                    if (s_r.dly > 16'h0001) begin
                        s_nxt.dly = s_r.dly - 16'h0001;
                    end else if (s_r.ost_pend) begin
                        s_nxt.ost_pend = 1'b0;
                        s_nxt.dly = 16'(OST_N);
                    end else if (!i_clk_cfg.pll_used || i_pll_lock) begin
                        s_nxt.st = RSW_WAIT_CLK;
                    end
                end
                RSW_WAIT_CLK: begin
                    if (i_osc_running || !i_clk_cfg.osc_crystal) begin
                        s_nxt.cpu_en = 1'b1;
                        s_nxt.per_en = 1'b1;
                        s_nxt.pc_load = ~s_r.sys_reset;
                        s_nxt.st = RSW_RUN;
                    end else if (i_clk_cfg.fail_safe_clock_monitor_en) begin
                        s_nxt.trap = 1'b1;
                        s_nxt.fast_rc = 1'b1;
                        s_nxt.pc_value = CLK_FAIL_VECTOR;
                        s_nxt.pc_load = 1'b1;
                        s_nxt.cpu_en = 1'b1;
                        s_nxt.per_en = 1'b1;
                        s_nxt.st = RSW_RUN;
                    end
                end
                default: s_nxt.st = RSW_RUN;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= '{st: RSW_RUN, rcr: RCR_RESET_VAL, wdt: '0, dly: 16'h0000,
                     ref_cnt: 8'h00, rc_sync: 3'h0, rc_lvl: 1'b0, ost_pend: 1'b0,
                     sys_reset: 1'b1, pc_load: 1'b0, pc_value: RESET_VECTOR,
                     cpu_en: 1'b1, per_en: 1'b1, osc_en: 1'b1, rc_en: 1'b0,
                     trap: 1'b0, fast_rc: 1'b0, osc_sel: 2'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rcr           = s_r.rcr;
    assign o_sys_reset     = s_r.sys_reset;
    assign o_pc_load       = s_r.pc_load;
    assign o_pc_value      = s_r.pc_value;
    assign o_cpu_clk_en    = s_r.cpu_en;
    assign o_periph_clk_en = s_r.per_en;
    assign o_osc_en        = s_r.osc_en;
    assign o_rc_en         = s_r.rc_en;
    assign o_lvd_en        = s_r.rcr[RCR_LOW_VOLTAGE_DETECT_ENABLE_BIT];
    assign o_lvd_level     = s_r.rcr[RCR_LOW_VOLTAGE_THRESHOLD_FIELD_LSB +: 4];
    assign o_clk_fail_trap = s_r.trap;
    assign o_use_fast_rc   = s_r.fast_rc;
    assign o_osc_sel       = s_r.osc_sel;
endmodule // rswps_ctrl

`default_nettype wire

// File: test/rswps_ctrl_chk.sv
/*
 checker for rswps_ctrl: reset flags, vectors, power-save gating.
 assumes it is bound to rswps_ctrl and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module rswps_ctrl_chk
    import rswps_pkg::*;
(
    input wire logic           i_clk,           // clock
    input wire logic           i_sys_rst,       // async reset
    input wire rsw_reset_req_t i_rst_req,       // reset requests
    input wire logic           i_psv_exec,      // power-save pulse
    input wire logic [1:0]     i_psv_mode,      // its operand
    input wire logic           i_irq_wake,      // interrupt wake
    input wire logic           i_rcr_we,        // register write
    input wire logic [15:0]    o_rcr,           // control register
    input wire logic           o_sys_reset,     // core reset
    input wire logic           o_pc_load,       // pc load pulse
    input wire logic [23:0]    o_pc_value,      // pc value
    input wire logic           o_cpu_clk_en,    // cpu clock gate
    input wire logic           o_periph_clk_en  // peripheral gate
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    por_flags_a:
        assert property (i_rst_req.por |=> o_rcr[1:0] == 2'h3 && o_rcr[15:14] == 2'h0
            && o_rcr[7:6] == 2'h0 && o_rcr[4:2] == 3'h0) else $error("por flags wrong");
    bor_flags_a:
        assert property (i_rst_req.bor && !i_rst_req.por |=> o_rcr[1:0] == 2'h2)
            else $error("bor flags wrong");
    ext_reset_a:
        assert property (i_rst_req.ext_pin && !i_rst_req.por && !i_rst_req.bor
            |=> o_rcr[7] && !o_rcr[4] && o_sys_reset) else $error("pin reset wrong");
    sw_reset_a:
        assert property (i_rst_req == 6'h04 |=> o_rcr[7:6] == 2'h1 && !o_rcr[4] && o_sys_reset)
            else $error("software reset wrong");
    rst_vector_a:
        assert property (i_rst_req != 6'h00 |=> o_pc_value == RESET_VECTOR)
            else $error("reset vector wrong");
    ref_ro_a:
        assert property (i_rcr_we && o_rcr[13] |=> o_rcr[13]) else $error("ref bit written");
    sleep_entry_a:
        assert property (i_psv_exec && i_psv_mode == PSV_SLEEP && o_cpu_clk_en && !o_sys_reset
            && i_rst_req == 6'h00 |=> !o_cpu_clk_en && !o_periph_clk_en) else $error("sleep entry");
    idle_wake_a:
        assert property (!o_cpu_clk_en && o_periph_clk_en && i_irq_wake && i_rst_req == 6'h00
            |=> o_cpu_clk_en && o_pc_load && o_rcr[2]) else $error("idle wake wrong");
endmodule // rswps_ctrl_chk
bind rswps_ctrl rswps_ctrl_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_rst_req(i_rst_req), .i_psv_exec(i_psv_exec), .i_psv_mode(i_psv_mode),
    .i_irq_wake(i_irq_wake), .i_rcr_we(i_rcr_we), .o_rcr(o_rcr), .o_sys_reset(o_sys_reset),
    .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_cpu_clk_en(o_cpu_clk_en),
    .o_periph_clk_en(o_periph_clk_en));
`default_nettype wire

// File: test/rswps_ctrl_tb.sv
/*
 self-checking bench for rswps_ctrl: reset causes, watchdog, sleep, idle.
 assumes small WDT_W and OST_N; pll reports lock; crystal ready except in fail-safe test.
*/
`timescale 1ns/10ps
`default_nettype none
module rswps_ctrl_tb;
    import rswps_pkg::*;
    typedef struct packed {logic [23:0] pc; logic [15:0] val;} rswps_note_t;
    logic           i_clk, i_sys_rst, i_rc_tick, i_wdt_fuse_en, i_wdt_clr, i_psv_exec;
    logic           i_irq_wake, i_rcr_we, prev_rst, osc_run;
    rsw_reset_req_t i_rst_req;
    rsw_clk_cfg_t   i_clk_cfg;
    logic [1:0]     i_psv_mode, o_osc_sel;
    logic [23:0]    i_irq_vector, i_pc, o_pc_value, v;
    logic [15:0]    i_rcr_wdata, o_rcr;
    logic [3:0]     o_lvd_level;
    logic           o_sys_reset, o_pc_load, o_cpu_clk_en, o_periph_clk_en, o_osc_en, o_rc_en;
    logic           o_lvd_en, o_clk_fail_trap, o_use_fast_rc;
    rswps_note_t    q[$], nt;
    int             error_cnt, checks, n;
    logic [15:0]    rexp [6] = '{16'h0003, 16'h00DE, 16'h0083, 16'h0043, 16'h80DF, 16'h40DF};
    rswps_ctrl #(.WDT_W(4), .OST_N(8)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_rst_req(i_rst_req), .i_rc_tick(i_rc_tick), .i_wdt_fuse_en(i_wdt_fuse_en),
        .i_wdt_clr(i_wdt_clr), .i_psv_exec(i_psv_exec), .i_psv_mode(i_psv_mode),
        .i_irq_wake(i_irq_wake), .i_irq_vector(i_irq_vector), .i_pc(i_pc),
        .i_clk_cfg(i_clk_cfg), .i_pll_lock(1'b1), .i_osc_running(osc_run), .i_rcr_we(i_rcr_we),
        .i_rcr_wdata(i_rcr_wdata), .o_rcr(o_rcr), .o_sys_reset(o_sys_reset),
        .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_cpu_clk_en(o_cpu_clk_en),
        .o_periph_clk_en(o_periph_clk_en), .o_osc_en(o_osc_en), .o_rc_en(o_rc_en),
        .o_lvd_en(o_lvd_en), .o_lvd_level(o_lvd_level), .o_clk_fail_trap(o_clk_fail_trap),
        .o_use_fast_rc(o_use_fast_rc), .o_osc_sel(o_osc_sel));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic wr(input logic [15:0] d);
        i_rcr_we = 1'b1;
        i_rcr_wdata = d;
        cyc(1);
        i_rcr_we = 1'b0;
        cyc(1);
    endtask
    task automatic pulse_req(input int k);
        i_rst_req = rsw_reset_req_t'(6'h20 >> k);
        cyc(1);
        i_rst_req = '0;
        cyc(30);
    endtask
    task automatic psv(input logic [1:0] m);
        i_wdt_clr = 1'b1;
        i_psv_exec = 1'b1;
        i_psv_mode = m;
        cyc(1);
        i_wdt_clr = 1'b0;
        i_psv_exec = 1'b0;
        cyc(3);
    endtask
    task automatic irq();
        i_irq_wake = 1'b1;
        cyc(1);
        i_irq_wake = 1'b0;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // results: a reset starting, or a wake loading a non-reset vector
    always @(negedge i_clk) begin
        prev_rst <= o_sys_reset;
        if (!i_sys_rst && ((o_sys_reset && !prev_rst) || (o_pc_load && o_pc_value !== 24'h0))) begin
            nt = (q.size() > 0) ? q.pop_front() : '1;
            chk(o_pc_value, nt.pc);
            chk({8'h00, o_rcr & 16'hC0DF}, {8'h00, nt.val});
        end
    end
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        i_rc_tick = 1'b0;
        forever #400 i_rc_tick = ~i_rc_tick;
    end
    initial begin
        #5000000;
        error_cnt++;
        test_done();
    end
    initial begin
        {i_wdt_fuse_en, i_wdt_clr, i_psv_exec, i_irq_wake, i_rcr_we, prev_rst} = '0;
        {i_rst_req, i_clk_cfg, i_psv_mode, i_irq_vector, i_pc, i_rcr_wdata} = '0;
        i_sys_rst = 1'b1;
        osc_run = 1'b1;
        v = $urandom(32'h17a2);
        cyc(16);
        i_sys_rst = 1'b0;
        cyc(2);
        chk(o_rcr, RCR_RESET_VAL);
        cyc(250);
        wr(16'h0000);
        chk(o_rcr, 16'h2000);
        v = $urandom;
        wr({3'h0, 1'b1, v[3:0], 8'hDF});
        wr({3'h0, 1'b1, v[3:0], 8'hDF});
        chk({o_lvd_en, o_lvd_level, o_rcr}, {1'b1, v[3:0], 3'h1, 1'b1, v[3:0], 8'hDF});
        wr(16'h0000);
        $display("test register done");
        for (int k = 0; k < 6; k++) begin
            wr(16'h00DF);
            q.push_back({RESET_VECTOR, rexp[k]});
            pulse_req(k);
        end
        wr(16'h0057);
        psv(PSV_SLEEP);
        q.push_back({RESET_VECTOR, 16'h00CB});
        pulse_req(2);
        cyc(200);
        wr(16'h005B);
        psv(PSV_IDLE);
        q.push_back({RESET_VECTOR, 16'h00C7});
        pulse_req(2);
        $display("test reset causes done");
        for (int c = 0; c < 2; c++) begin
            i_clk_cfg = {1'(c), 1'(c), 3'h1, 2'(c + 1), 2'h0};
            wr(16'h0000);
            v = $urandom | 24'h100;
            i_irq_vector = v;
            psv(PSV_SLEEP);
            chk({o_cpu_clk_en, o_periph_clk_en, o_osc_en}, 24'h0);
            q.push_back({v, 16'h0008});
            irq();
            n = 0;
            while (!o_pc_load && n < 2000) begin
                cyc(1);
                n++;
            end
            chk(24'(n >= SHORT_DELAY_CYC - 2 + 8 * c), 24'h1);
            cyc(2);
            chk(o_osc_sel, 24'(c + 1));
        end
        // crystal never starts: fail-safe monitor must trap to the fast rc
        osc_run = 1'b0;
        i_clk_cfg.fail_safe_clock_monitor_en = 1'b1;
        wr(16'h0000);
        psv(PSV_SLEEP);
        q.push_back({CLK_FAIL_VECTOR, 16'h0008});
        irq();
        n = 0;
        while (!o_pc_load && n < 2000) begin
            cyc(1);
            n++;
        end
        chk({o_clk_fail_trap, o_use_fast_rc}, 24'h3);
        osc_run = 1'b1;
        i_clk_cfg.fail_safe_clock_monitor_en = 1'b0;
        cyc(2);
        wr(16'h0000);
        psv(PSV_IDLE);
        chk({o_cpu_clk_en, o_periph_clk_en}, 24'h1);
        q.push_back({v, 16'h0004});
        irq();
        chk(o_cpu_clk_en, 24'h1);
        cyc(5);
        $display("test sleep idle done");
        for (int f = 0; f < 2; f++) begin
            i_wdt_fuse_en = 1'(f);
            wr(f ? 16'h00CC : 16'h00EC);
            q.push_back({RESET_VECTOR, 16'h0010});
            cyc(170);
            i_wdt_fuse_en = 1'b0;
            wr(16'h0000);
        end
        wr(16'h0020);
        chk(o_rc_en, 24'h1);
        repeat (12) begin
            i_wdt_clr = 1'b1;
            cyc(1);
            i_wdt_clr = 1'b0;
            cyc(40);
        end
        i_pc = {$urandom} & 24'hFFFFFE;
        psv(PSV_SLEEP);
        q.push_back({i_pc + PC_STEP, 16'h0018});
        cyc(150);
        wr(16'h0018);
        cyc(200);
        chk(24'(q.size()), 24'h0);
        $display("test watchdog done");
        test_done();
    end
endmodule // rswps_ctrl_tb
`default_nettype wire
